// File: rtl/qpdt_pkg.sv
// constants, register map and field layout of the quad down timer
package qpdt_pkg;
	localparam int NUM_TIMERS = 4;
	localparam int ADDR_W = 8;
	localparam int IDX_W = 6;
	// register word indices, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_CTRL = 6'h00;
	localparam logic [IDX_W-1:0] IDX_TCTL = 6'h01;
	localparam logic [IDX_W-1:0] IDX_RELOAD = 6'h05;
	localparam logic [IDX_W-1:0] IDX_READBACK = 6'h09;
	localparam logic [IDX_W-1:0] IDX_FLAGS = 6'h0D;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_TCTL0 = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_RELOAD0 = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_READBACK0 = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h34;
	// global control fields
	localparam int CTRL_WIDTH_A = 0;
	localparam int CTRL_WIDTH_B = 1;
	localparam int CTRL_HSEL = 2;
	// per-timer control fields
	localparam int TC_RUN = 0;
	localparam int TC_PRESET = 1;
	localparam int TC_REPEAT = 2;
	localparam int TC_DIV = 3;
	localparam int TC_SRC = 5;
	localparam int TC_POL = 6;
	localparam int TC_FUNC = 7;
	localparam int TC_EXT = 8;
	localparam int TC_W = 9;
	// reset values
	localparam logic [7:0] RELOAD_RST = 8'hFF;
	localparam logic [7:0] COUNT_RST = 8'hFF;
	localparam logic [TC_W-1:0] TCTL_RST = 9'h000;
	// prescaler divide codes and terminal counts
	localparam logic [1:0] DIV_1 = 2'h0;
	localparam logic [1:0] DIV_4 = 2'h1;
	localparam logic [1:0] DIV_16 = 2'h2;
	localparam logic [1:0] DIV_64 = 2'h3;
	localparam logic [5:0] PRE_LAST_1 = 6'h00;
	localparam logic [5:0] PRE_LAST_4 = 6'h03;
	localparam logic [5:0] PRE_LAST_16 = 6'h0F;
	localparam logic [5:0] PRE_LAST_64 = 6'h3F;
	// noise rejecter clock taken from the slow oscillator
	localparam int SLOW_HZ = 32768;
	localparam int NR_HZ = 2048;
	localparam logic [3:0] NR_LAST = 4'((SLOW_HZ / NR_HZ) - 1);
	localparam logic [1:0] NR_EDGES_LAST = 2'h1;
	localparam int NR_MIN_PULSE_US = 980;
endpackage

// File: rtl/qpdt_prescaler.sv
// source clock divider of one timer, /1 /4 /16 /64
`timescale 1ns/1ps
module qpdt_prescaler
	import qpdt_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// control
	input wire logic run,
	input wire logic [1:0] divSel,
	// ticks
	input wire logic tickIn,
	output logic tickOut
);
	logic [5:0] cnt_ff;
	logic [5:0] last;

	always_comb
	begin
		case (divSel)
			DIV_1: last = PRE_LAST_1;
			DIV_4: last = PRE_LAST_4;
			DIV_16: last = PRE_LAST_16;
			DIV_64: last = PRE_LAST_64;
			default: last = PRE_LAST_1;
		endcase
	end

	assign tickOut = run & tickIn & (cnt_ff >= last);

	// source reaches the divider only while running
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			cnt_ff <= 6'h00;
		else if (!run || tickOut)
			cnt_ff <= 6'h00;
		else if (tickIn)
			cnt_ff <= cnt_ff + 6'h01;
	end
endmodule

// File: rtl/qpdt_noise_rejecter.sv
// input level accepted after two falling edges of the 2048 Hz clock
`timescale 1ns/1ps
module qpdt_noise_rejecter
	import qpdt_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// synchronised level and 2048 Hz falling edge
	input wire logic levelIn,
	input wire logic edgeTick,
	// filtered level
	output logic levelOut
);
	logic [1:0] cnt_ff;
	logic level_ff;

	assign levelOut = level_ff;

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_ff <= 2'h0;
			level_ff <= 1'b0;
		end
		else if (levelIn == level_ff)
			cnt_ff <= 2'h0;
		else if (edgeTick)
		begin
			if (cnt_ff == NR_EDGES_LAST)
			begin
				level_ff <= levelIn;
				cnt_ff <= 2'h0;
			end
			else
				cnt_ff <= cnt_ff + 2'h1;
		end
	end
endmodule

// File: rtl/qpdt_top.sv
// four 8-bit down timers in two cascadable pairs, APB register access
//
// Contract
// RULE1 - four 8-bit down counters with own reload values, in two cascadable pairs
// RULE2 - writing one to preset strobe copies reload value into the counter
// RULE3 - run control one counts on input clock, zero halts counting
// RULE4 - stopping or starting keeps the counter value unchanged
// RULE5 - software reads each live counter value at any time
// RULE6 - underflow reloads the counter and emits an underflow pulse
// RULE7 - repeat select one reloads and keeps counting on each underflow
// RULE8 - repeat select zero reloads, stops and clears run control on underflow
// RULE9 - width select zero: pair works as two independent 8-bit timers
// RULE10 - width select one: first timer low byte, second high byte, first controls
// RULE11 - in 16-bit mode second timer run control is held at zero
// RULE12 - source select zero takes slow oscillator, one takes fast oscillator
// RULE13 - in 16-bit mode source and divide come from the first timer
// RULE14 - divide select 11 /64, 10 /16, 01 /4, 00 /1
// RULE15 - source clock reaches prescaler only while run control is one
// RULE16 - external count select clocks first timer from its input pin
// RULE17 - in event counting the first timer divide setting has no effect
// RULE18 - polarity zero counts falling edges, one counts rising edges
// RULE19 - noise rejecter clocks count at second 2048 Hz falling edge
// RULE20 - pulse-width mode gates prescaler clocks by measured input level
// RULE21 - pulse-width in 16-bit mode measures with the whole pair
// RULE22 - halved underflow rate of pair A drives the output pin
// RULE23 - underflow sets flag; in 16-bit mode only second timer flag sets
// RULE24 - halved output source select picks timer; 16-bit uses 16-bit underflow
// RULE25 - 16-bit high byte decrements on low byte underflow; pair reloads at zero
// RULE26 - external pins are synchronised before edge, level or noise logic
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module qpdt_top
	import qpdt_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// apb slave
	input wire logic [qpdt_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// oscillators and count inputs
	input wire logic slowOscillator,
	input wire logic fastOscillator,
	input wire logic inputPinA,
	input wire logic inputPinB,
	// outputs
	output logic outputPortPin,
	output logic [qpdt_pkg::NUM_TIMERS-1:0] underflowPulse
);
	import qpdt_pkg::*;

	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [3:0] syn1_ff, syn2_ff, syn3_ff, lvl_ff, lvlPrev_ff;
	logic [3:0] nrCnt_ff;
	logic [1:0] nrPrev_ff;
	logic [1:0] nrLvl;
	logic widthA_ff, widthB_ff, hsel_ff;
	logic [TC_W-1:0] tctl_ff [NUM_TIMERS];
	logic [7:0] reload_ff [NUM_TIMERS];
	logic [7:0] cnt_ff [NUM_TIMERS];
	logic [3:0] run_ff;
	logic [3:0] flag_ff;
	logic halved_ff;
	logic [3:0] ufPulse_ff;
	logic slowTick, fastTick, nrFall;
	logic setup, wrEn, hit;
	logic [IDX_W-1:0] idx;
	logic [31:0] rdMux;
	logic [3:0] wrTctl, preTick, tick, dec, reloadEv, presetLd, uf, stopRun, setFlag;
	logic [3:0] wide4;
	logic halvedSrc;

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign outputPortPin = halved_ff;
	assign underflowPulse = ufPulse_ff;

	// three-stage pin synchronisers, level accepted once stages two and three agree
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			syn1_ff <= 4'h0;
			syn2_ff <= 4'h0;
			syn3_ff <= 4'h0;
		end
		else
		begin
			syn1_ff <= {inputPinB, inputPinA, fastOscillator, slowOscillator}; // [RULE26]
			syn2_ff <= syn1_ff;
			syn3_ff <= syn2_ff;
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			lvl_ff <= 4'h0;
			lvlPrev_ff <= 4'h0;
		end
		else
		begin
			for (int i = 0; i < 4; i++)
				if (syn2_ff[i] == syn3_ff[i])
					lvl_ff[i] <= syn3_ff[i]; // [RULE26]
			lvlPrev_ff <= lvl_ff;
		end
	end

	assign slowTick = lvl_ff[0] & ~lvlPrev_ff[0];
	assign fastTick = lvl_ff[1] & ~lvlPrev_ff[1];
	assign nrFall = slowTick & (nrCnt_ff == NR_LAST);

	// 2048 Hz falling edge derived from the slow oscillator
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			nrCnt_ff <= 4'h0;
		else if (slowTick)
			nrCnt_ff <= nrCnt_ff + 4'h1;
	end

	for (genvar p = 0; p < 2; p++)
	begin : g_nr
		qpdt_noise_rejecter u_nr (
			.mclk(mclk),
			.resetn(resetn),
			.levelIn(lvl_ff[2+p]),
			.edgeTick(nrFall),
			.levelOut(nrLvl[p])
		); // [RULE19]
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			nrPrev_ff <= 2'h0;
		else
			nrPrev_ff <= nrLvl;
	end

	assign wide4 = {widthB_ff, widthB_ff, widthA_ff, widthA_ff};

	for (genvar i = 0; i < NUM_TIMERS; i++)
	begin : g_pre
		qpdt_prescaler u_pre (
			.mclk(mclk),
			.resetn(resetn),
			.run(run_ff[i]), // [RULE15]
			.divSel(tctl_ff[i][TC_DIV +: 2]), // [RULE14]
			.tickIn(tctl_ff[i][TC_SRC] ? fastTick : slowTick), // [RULE12]
			.tickOut(preTick[i])
		);
	end

	// apb decode, zero wait states
	assign setup = psel & ~penable;
	assign wrEn = psel & penable & pready_ff & pwrite;
	assign idx = paddr[ADDR_W-1:2];
	assign hit = (paddr[1:0] == 2'h0) && (idx <= IDX_FLAGS);

	for (genvar i = 0; i < NUM_TIMERS; i++)
	begin : g_wr
		assign wrTctl[i] = wrEn && hit && (idx == IDX_TCTL + IDX_W'(i));
	end

	always_comb
	begin
		rdMux = 32'h0000_0000;
		if (idx == IDX_CTRL)
			rdMux = {29'h0, hsel_ff, widthB_ff, widthA_ff};
		else if (idx == IDX_FLAGS)
			rdMux = {28'h0, flag_ff};
		for (int i = 0; i < NUM_TIMERS; i++)
		begin
			if (idx == IDX_TCTL + IDX_W'(i))
				rdMux = {23'h0, tctl_ff[i][TC_W-1:TC_REPEAT], 1'b0, run_ff[i]};
			if (idx == IDX_RELOAD + IDX_W'(i))
				rdMux = {24'h0, reload_ff[i]};
			if (idx == IDX_READBACK + IDX_W'(i))
				rdMux = {24'h0, cnt_ff[i]}; // [RULE5]
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end
		else
		begin
			pready_ff <= setup;
			pslverr_ff <= setup & ~hit;
			prdata_ff <= (setup && hit && !pwrite) ? rdMux : 32'h0000_0000;
		end
	end

	// configuration registers
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			widthA_ff <= 1'b0;
			widthB_ff <= 1'b0;
			hsel_ff <= 1'b0;
			for (int i = 0; i < NUM_TIMERS; i++)
			begin
				tctl_ff[i] <= TCTL_RST;
				reload_ff[i] <= RELOAD_RST;
			end
		end
		else if (wrEn && hit)
		begin
			if (idx == IDX_CTRL)
			begin
				widthA_ff <= pwdata[CTRL_WIDTH_A];
				widthB_ff <= pwdata[CTRL_WIDTH_B];
				hsel_ff <= pwdata[CTRL_HSEL];
			end
			for (int i = 0; i < NUM_TIMERS; i++)
			begin
				if (wrTctl[i])
				begin
					tctl_ff[i] <= pwdata[TC_W-1:0] & 9'h1FC;
					if (i % 2 == 1)
						tctl_ff[i][TC_EXT] <= 1'b0; // [RULE16]
				end
				if (idx == IDX_RELOAD + IDX_W'(i))
					reload_ff[i] <= pwdata[7:0];
			end
		end
	end

	// per-pair clocking, cascade and underflow
	always_comb
	begin
		tick = 4'h0;
		dec = 4'h0;
		reloadEv = 4'h0;
		presetLd = 4'h0;
		uf = 4'h0;
		stopRun = 4'h0;
		setFlag = 4'h0;
		for (int p = 0; p < 2; p++)
		begin
			logic ext, fn, pol, cur, prv, evEdge, uf16;
			ext = tctl_ff[2*p][TC_EXT];
			fn = tctl_ff[2*p][TC_FUNC];
			pol = tctl_ff[2*p][TC_POL];
			cur = fn ? nrLvl[p] : lvl_ff[2+p]; // [RULE19]
			prv = fn ? nrPrev_ff[p] : lvlPrev_ff[2+p];
			evEdge = pol ? (cur & ~prv) : (~cur & prv); // [RULE18]
			uf16 = 1'b0;
			// event input replaces the prescaler, level gates it in pulse-width mode
			tick[2*p] = run_ff[2*p] & (ext ? evEdge
				: (preTick[2*p] & (~fn | (lvl_ff[2+p] == pol)))); // [RULE3] [RULE16] [RULE17] [RULE20]
			if (wide4[2*p])
			begin
				tick[2*p+1] = tick[2*p] & (cnt_ff[2*p] == 8'h00); // [RULE25] [RULE21]
				uf16 = tick[2*p+1] & (cnt_ff[2*p+1] == 8'h00);
				dec[2*p] = tick[2*p] & ~uf16;
				dec[2*p+1] = tick[2*p+1] & ~uf16;
				reloadEv[2*p] = uf16;
				reloadEv[2*p+1] = uf16; // [RULE25]
				uf[2*p+1] = uf16;
				setFlag[2*p+1] = uf16; // [RULE23]
				stopRun[2*p] = uf16 & ~tctl_ff[2*p][TC_REPEAT]; // [RULE10]
				presetLd[2*p] = wrTctl[2*p] & pwdata[TC_PRESET];
				presetLd[2*p+1] = presetLd[2*p];
			end
			else
			begin
				tick[2*p+1] = run_ff[2*p+1] & preTick[2*p+1]; // [RULE9]
				for (int j = 2*p; j < 2*p+2; j++)
				begin
					dec[j] = tick[j] & (cnt_ff[j] != 8'h00);
					reloadEv[j] = tick[j] & (cnt_ff[j] == 8'h00); // [RULE6]
					uf[j] = reloadEv[j];
					setFlag[j] = reloadEv[j]; // [RULE23]
					stopRun[j] = reloadEv[j] & ~tctl_ff[j][TC_REPEAT]; // [RULE8]
					presetLd[j] = wrTctl[j] & pwdata[TC_PRESET];
				end
			end
		end
	end

	// down counters
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < NUM_TIMERS; i++)
				cnt_ff[i] <= COUNT_RST;
		end
		else
		begin
			for (int i = 0; i < NUM_TIMERS; i++)
			begin
				if (presetLd[i])
					cnt_ff[i] <= reload_ff[i]; // [RULE2]
				else if (reloadEv[i])
					cnt_ff[i] <= reload_ff[i]; // [RULE6] [RULE7]
				else if (dec[i])
					cnt_ff[i] <= cnt_ff[i] - 8'h01; // [RULE1] [RULE4]
			end
		end
	end

	// run control, software write wins over the one-shot stop
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			run_ff <= 4'h0;
		else
		begin
			for (int i = 0; i < NUM_TIMERS; i++)
			begin
				if (i % 2 == 1 && wide4[i])
					run_ff[i] <= 1'b0; // [RULE11] [RULE13]
				else if (wrTctl[i])
					run_ff[i] <= pwdata[TC_RUN]; // [RULE3]
				else if (stopRun[i])
					run_ff[i] <= 1'b0; // [RULE8]
			end
		end
	end

	// underflow flags, write one to clear, set wins
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			flag_ff <= 4'h0;
		else if (wrEn && hit && idx == IDX_FLAGS)
			flag_ff <= (flag_ff & ~pwdata[3:0]) | setFlag; // [RULE23]
		else
			flag_ff <= flag_ff | setFlag;
	end

	// halved underflow output and underflow pulses
	assign halvedSrc = (widthA_ff | hsel_ff) ? uf[1] : uf[0]; // [RULE24]

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			halved_ff <= 1'b0;
			ufPulse_ff <= 4'h0;
		end
		else
		begin
			if (halvedSrc)
				halved_ff <= ~halved_ff; // [RULE22]
			ufPulse_ff <= uf; // [RULE6]
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	chk_preset_load: assert property (presetLd[0] |=> cnt_ff[0] == $past(reload_ff[0])) // [RULE2]
		else $error("preset did not load reload value");
	chk_stop_hold: assert property ((!run_ff[0] && !presetLd[0] && !widthA_ff)
		|=> cnt_ff[0] == $past(cnt_ff[0])) // [RULE4]
		else $error("stopped counter changed");
	chk_oneshot_stop: assert property ((stopRun[0] && !wrTctl[0] && !widthA_ff)
		|=> !run_ff[0] && cnt_ff[0] == $past(reload_ff[0])) // [RULE8]
		else $error("one-shot did not stop with reload");
	chk_repeat_run: assert property ((uf[0] && tctl_ff[0][TC_REPEAT] && !wrTctl[0])
		|=> run_ff[0] ##1 run_ff[0]) // [RULE7]
		else $error("continuous timer stopped");
	chk_wide_run: assert property ($past(widthA_ff) && widthA_ff |-> !run_ff[1]) // [RULE11]
		else $error("high timer running in 16-bit mode");
	chk_wide_flag: assert property (widthA_ff && !flag_ff[0] |=> !flag_ff[0]) // [RULE23]
		else $error("low flag set in 16-bit mode");
	chk_halved_toggle: assert property (halvedSrc |=> halved_ff != $past(halved_ff)) // [RULE22]
		else $error("halved output missed an underflow");
	chk_readback_data: assert property ((setup && !pwrite && paddr == OFF_READBACK0)
		|=> prdata_ff == {24'h0, $past(cnt_ff[0])}) // [RULE5]
		else $error("readback mismatch");
	chk_pw_gate: assert property ((tctl_ff[0][TC_FUNC] && !tctl_ff[0][TC_EXT]
		&& lvl_ff[2] != tctl_ff[0][TC_POL]) |-> !tick[0]) // [RULE20]
		else $error("pulse-width counted at wrong level");
	chk_wide_cascade: assert property ((widthA_ff && tick[1]) |-> cnt_ff[0] == 8'h00) // [RULE25]
		else $error("high byte stepped without low underflow");

	cov_oneshot: cover property (stopRun[0] ##1 !run_ff[0]);
	cov_wide_uf: cover property (widthA_ff && uf[1]);
	cov_event_count: cover property (tctl_ff[0][TC_EXT] && tick[0]);
	cov_pulse_width: cover property (tctl_ff[2][TC_FUNC] && !tctl_ff[2][TC_EXT] && tick[2]);
endmodule

// File: test/qpdt_pin_model.sv
// behavioural source of count and measure levels on an input pin
`timescale 1ns/1ps
module qpdt_pin_model
(
	// clock
	input wire logic mclk,
	// driven pin
	output logic pin
);
	initial pin = 1'b0;
	// each level held well past the synchroniser latency
	task automatic level(input logic v);
		@(posedge mclk);
		pin <= v;
		repeat (10) @(posedge mclk);
	endtask
	// whole pulses, idle low between them
	task automatic pulses(input int n);
		repeat (n)
		begin
			level(1'b1);
			level(1'b0);
		end
	endtask
endmodule

// File: test/test_qpdt_top.sv
// self-checking bench of the quad down timer over apb
`timescale 1ns/1ps
module test_qpdt_top;
	import qpdt_pkg::*;
	logic mclk;
	logic resetn;
	logic [ADDR_W-1:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic slowOsc;
	logic fastOsc;
	logic pinA;
	logic pinB;
	logic outPin;
	logic [3:0] ufPulse;
	logic [32:0] expQ[$];
	string nameQ[$];
	int ufCnt[4] = '{0, 0, 0, 0};
	int failures = 0;
	int nTests = 0;
	int seed = 95;
	logic [7:0] r;
	qpdt_top DUT (.mclk(mclk), .resetn(resetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .slowOscillator(slowOsc),
		.fastOscillator(fastOsc), .inputPinA(pinA), .inputPinB(pinB),
		.outputPortPin(outPin), .underflowPulse(ufPulse));
	qpdt_pin_model partner (.mclk(mclk), .pin(pinA));
	qpdt_pin_model partnerB (.mclk(mclk), .pin(pinB));
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] s);
		nTests++;
		if (s !== e)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		k = 0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge mclk);
		penable <= 1'b1;
		do
		begin
			@(posedge mclk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e, input string nm);
		expQ.push_back(e);
		nameQ.push_back(nm);
		apb(a, 1'b0, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	// exact number of rising edges on one oscillator input
	task automatic osc(input logic fast, input int n);
		repeat (n)
		begin
			repeat (4) @(posedge mclk);
			fastOsc <= fast;
			slowOsc <= !fast;
			repeat (4) @(posedge mclk);
			fastOsc <= 1'b0;
			slowOsc <= 1'b0;
		end
		repeat (12) @(posedge mclk);
	endtask
	task automatic done(input string nm);
		$display("test %s done", nm);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", nTests, failures);
		if (failures == 0 && nTests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// read results checked against the oldest note
	always @(posedge mclk)
	begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk(nameQ.pop_front(), expQ.pop_front(), {pslverr, prdata});
		for (int i = 0; i < 4; i++)
			if (ufPulse[i] === 1'b1)
				ufCnt[i]++;
	end
	initial
	begin
		repeat (40000) @(posedge mclk);
		failures++;
		finish_test();
	end
	initial
	begin
		resetn <= 1'b0;
		paddr <= 8'h00;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		pwdata <= 32'h0;
		slowOsc <= 1'b0;
		fastOsc <= 1'b0;
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		for (int i = 0; i < 4; i++)
		begin
			rd(OFF_RELOAD0 + 8'(4 * i), 8'hFF, "reload");
			rd(OFF_READBACK0 + 8'(4 * i), 8'hFF, "count");
			rd(OFF_TCTL0 + 8'(4 * i), 8'h00, "tctl");
		end
		rd(OFF_FLAGS, 8'h00, "flags");
		rd(8'h38, 33'h100000000, "unmapped");
		rd(8'h05, 33'h100000000, "misaligned");
		done("reset");
		r = 8'($random(seed));
		wr(OFF_RELOAD0, {24'h0, r});
		wr(OFF_TCTL0, 32'h2);
		rd(OFF_READBACK0, r, "preset");
		rd(OFF_TCTL0, 8'h00, "strobe");
		done("preset");
		// events with divide /64 set, which must not matter
		wr(OFF_RELOAD0, 32'h20);
		wr(OFF_TCTL0, 32'h15F);
		partner.pulses(5);
		rd(OFF_READBACK0, 8'h1B, "events");
		partner.level(1'b1);
		rd(OFF_READBACK0, 8'h1A, "rise");
		wr(OFF_TCTL0, 32'h11D);
		partner.level(1'b0);
		rd(OFF_READBACK0, 8'h19, "fall");
		wr(OFF_TCTL0, 32'h11C);
		partner.pulses(3);
		rd(OFF_READBACK0, 8'h19, "stopped");
		wr(OFF_TCTL0, 32'h11D);
		partner.pulses(2);
		rd(OFF_READBACK0, 8'h17, "resumed");
		done("events");
		wr(OFF_RELOAD0, 32'h2);
		wr(OFF_TCTL0, 32'h103);
		partner.pulses(2);
		rd(OFF_READBACK0, 8'h00, "zero");
		partner.pulses(1);
		rd(OFF_READBACK0, 8'h02, "reloaded");
		rd(OFF_TCTL0, 33'h100, "run cleared");
		chk("pulses", 33'h1, 33'(ufCnt[0]));
		rd(OFF_FLAGS, 8'h01, "flag set");
		wr(OFF_FLAGS, 32'h1);
		rd(OFF_FLAGS, 8'h00, "flag clear");
		partner.pulses(2);
		rd(OFF_READBACK0, 8'h02, "halted");
		wr(OFF_TCTL0, 32'h105);
		partner.pulses(6);
		rd(OFF_READBACK0, 8'h02, "repeat");
		chk("repeat pulses", 33'h3, 33'(ufCnt[0]));
		chk("halved out", 33'h1, {32'h0, outPin});
		done("underflow");
		wr(OFF_TCTL0, 32'h0);
		wr(OFF_FLAGS, 32'hF);
		wr(OFF_CTRL, 32'h1);
		wr(OFF_RELOAD0, 32'h1);
		wr(OFF_RELOAD0 + 8'h04, 32'h0);
		wr(OFF_TCTL0, 32'h107);
		partner.pulses(2);
		rd(OFF_READBACK0, 8'h01, "pair reload");
		rd(OFF_FLAGS, 8'h02, "pair flag");
		chk("pair pulse", 33'h1, 33'(ufCnt[1]));
		chk("low pulse", 33'h3, 33'(ufCnt[0]));
		chk("pair out", 33'h0, {32'h0, outPin});
		wr(OFF_RELOAD0, 32'h0);
		wr(OFF_RELOAD0 + 8'h04, 32'h1);
		wr(OFF_TCTL0, 32'h107);
		partner.pulses(1);
		rd(OFF_READBACK0, 8'hFF, "low wrap");
		rd(OFF_READBACK0 + 8'h04, 8'h00, "high byte");
		wr(OFF_TCTL0, 32'h0);
		wr(OFF_CTRL, 32'h0);
		done("pair");
		for (int d = 0; d < 4; d++)
		begin
			wr(OFF_RELOAD0 + 8'h0C, 32'h10);
			wr(OFF_TCTL0 + 8'h0C, 32'(32'h27 | (d << 3)));
			osc(1'b1, 2 << (2 * d));
			rd(OFF_READBACK0 + 8'h0C, 8'h0E, "divide");
			wr(OFF_TCTL0 + 8'h0C, 32'h0);
		end
		rd(OFF_READBACK0 + 8'h08, 8'hFF, "neighbour");
		wr(OFF_TCTL0 + 8'h0C, 32'h7);
		osc(1'b1, 3);
		osc(1'b0, 3);
		rd(OFF_READBACK0 + 8'h0C, 8'h0D, "slow source");
		done("prescaler");
		wr(OFF_RELOAD0, 32'h30);
		wr(OFF_TCTL0, 32'hE7);
		osc(1'b1, 5);
		rd(OFF_READBACK0, 8'h30, "low gated");
		partner.level(1'b1);
		osc(1'b1, 5);
		rd(OFF_READBACK0, 8'h2B, "high measured");
		partner.level(1'b0);
		done("width");
		// pair b event count through the noise rejecter, rising edges, one-shot
		wr(OFF_RELOAD0 + 8'h08, 32'h1);
		wr(OFF_TCTL0 + 8'h08, 32'h1C3);
		partnerB.level(1'b1);
		osc(1'b0, 40);
		rd(OFF_READBACK0 + 8'h08, 8'h00, "filtered rise");
		// short low glitch with no 2048 Hz edge inside it
		partnerB.level(1'b0);
		partnerB.level(1'b1);
		osc(1'b0, 40);
		rd(OFF_READBACK0 + 8'h08, 8'h00, "glitch rejected");
		partnerB.level(1'b0);
		osc(1'b0, 40);
		partnerB.level(1'b1);
		osc(1'b0, 40);
		rd(OFF_READBACK0 + 8'h08, 8'h01, "filtered wrap");
		rd(OFF_TCTL0 + 8'h08, 33'h1C0, "b run cleared");
		chk("pair b pulse", 33'h1, 33'(ufCnt[2]));
		done("noise");
		finish_test();
	end
endmodule
